// *** hw/ttp_trigger_preload.sv ***
// Purpose: Trigger output selection, DMA timing and channel bit preload.
// Assumes: Core events are one-cycle pulses synchronous to sys_clk_in.
// Notes: Register port answers reads one cycle later.
// Functional notes
// - Reset trigger output lags slave-mode reset.
// - Code 001 outputs counter run signal.
// - Trigger-controlled enable delayed unless sync mode.
// - Code 010 outputs update event.
// - Code 011 pulses on every channel-1 event.
// - Codes 100-110 output channel references 1-3.
// - Bit 3 picks update or channel DMA timing.
// - Bit 2 adds trigger rising edge transfer.
// - Bit 0 preloads bits until commutation.
`timescale 1ns/1ps
`default_nettype none
`include "ttp_defs.svh"
module ttp_trigger_preload #(
    parameter int CHAN_BITS = `TTP_CHAN_BITS
) (
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Register port.
    input wire ttp_pkg::ttp_bus_s bus_in,
    output logic [15:0] rdata_out,
    // Timer core signals.
    input wire ttp_pkg::ttp_core_s core_in,
    input wire logic [CHAN_BITS-1:0] chan_bits_in,
    // Results.
    output logic sync_trigger_out,
    output logic dma_req_out,
    output logic [CHAN_BITS-1:0] chan_bits_active_out
);
    import ttp_pkg::*;

    logic rst_s1_q;
    logic rst_s2_q;
    logic [15:0] ctl_q;
    logic [15:0] rdata_q;
    logic trig_q;
    logic dma_q;
    logic trig_in_q;
    logic [CHAN_BITS-1:0] act_q;
    logic reset_late;
    logic run_late;
    logic gate_late;

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    wire rst_n = rst_s2_q;
    wire ctl_hit = bus_in.addr == `TTP_CTL2_OFFSET;
    wire shd_hit = bus_in.addr == `TTP_SHADOW_OFFSET;
    wire [15:0] ctl_d = bus_in.wdata & `TTP_CTL2_MASK;
    wire [15:0] rd_mux = ctl_hit ? ctl_q :
        shd_hit ? 16'(act_q) : 16'h0000;
    wire ttp_tsel_e trig_sel = ttp_tsel_e'(ctl_q[`TTP_TSEL_MSB:`TTP_TSEL_LSB]);
    wire dma_sel = ctl_q[`TTP_BIT_DMA_SEL];
    wire upd_src = ctl_q[`TTP_BIT_UPD_SRC];
    wire preload = ctl_q[`TTP_BIT_PRELOAD];
    wire run_now = core_in.counter_run_bit | core_in.gated_trigger;
    wire trig_in_rise = core_in.trigger_input & ~trig_in_q;
    wire transfer = core_in.commutate | (upd_src & trig_in_rise);
    wire dma_d = dma_sel ? core_in.update_event : core_in.chan_event;
    wire slave_reset_event = core_in.reset_event & core_in.slave_reset;
    wire gate_free = core_in.gated_trigger & ~core_in.master_slave_sync;
    // A reset from the slave controller leaves one cycle later.
    ttp_sync_delay #(.DEPTH(`TTP_TRIG_LAG)) u_reset_dly (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n),
        .d_in(slave_reset_event),
        .q_out(reset_late)
    );
    ttp_sync_delay #(.DEPTH(`TTP_TRIG_LAG)) u_run_dly (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n),
        .d_in(run_now),
        .q_out(run_late)
    );
    // The gate condition is delayed as well, so that the falling edge of a
    // trigger-driven enable lags by the same cycle as its rising edge.
    ttp_sync_delay #(.DEPTH(`TTP_TRIG_LAG)) u_gate_dly (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n),
        .d_in(gate_free),
        .q_out(gate_late)
    );
    wire reset_src = (core_in.reset_event & ~core_in.slave_reset) | reset_late;
    wire gate_ctrl = (core_in.gated_trigger | gate_late) & ~core_in.master_slave_sync;
    wire run_src = gate_ctrl ? run_late : run_now;
    logic trig_d;
    always_comb
    begin
        case (trig_sel)
            TTP_TSEL_RESET: trig_d = reset_src;
            TTP_TSEL_ENABLE: trig_d = run_src;
            TTP_TSEL_UPDATE: trig_d = core_in.update_event;
            TTP_TSEL_CMP_PULSE: trig_d = core_in.chan1_capture;
            TTP_TSEL_OC1: trig_d = core_in.out_ref[0];
            TTP_TSEL_OC2: trig_d = core_in.out_ref[1];
            TTP_TSEL_OC3: trig_d = core_in.out_ref[2];
            default: trig_d = 1'b0;
        endcase
    end
    wire [CHAN_BITS-1:0] act_d = (!preload || transfer) ? chan_bits_in : act_q;

    always_ff @(posedge sys_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_q <= `TTP_CTL2_RESET;
            rdata_q <= 16'h0000;
            trig_q <= 1'b0;
            dma_q <= 1'b0;
            trig_in_q <= 1'b0;
            act_q <= '0;
        end
        else
        begin
            if (bus_in.wr && ctl_hit)
                ctl_q <= ctl_d;
            rdata_q <= bus_in.rd ? rd_mux : 16'h0000;
            trig_q <= trig_d;
            dma_q <= dma_d;
            trig_in_q <= core_in.trigger_input;
            act_q <= act_d;
        end
    end

    assign rdata_out = rdata_q;
    assign sync_trigger_out = trig_q;
    assign dma_req_out = dma_q;
    assign chan_bits_active_out = act_q;

    // Direct selections: the output follows its source one cycle later.
    upd_sel_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (trig_sel == TTP_TSEL_UPDATE && core_in.update_event) |=> sync_trigger_out)
        else $error("update not on trigger output");

    cmp_pulse_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (trig_sel == TTP_TSEL_CMP_PULSE) |=> sync_trigger_out == $past(core_in.chan1_capture))
        else $error("compare pulse mismatch");

    oc1_sel_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (trig_sel == TTP_TSEL_OC1) |=> sync_trigger_out == $past(core_in.out_ref[0]))
        else $error("channel one reference mismatch");

    oc_sel_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (trig_sel == TTP_TSEL_OC2) |=> sync_trigger_out == $past(core_in.out_ref[1]))
        else $error("channel reference mismatch");

    oc3_sel_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (trig_sel == TTP_TSEL_OC3) |=> sync_trigger_out == $past(core_in.out_ref[2]))
        else $error("channel three reference mismatch");

    rsvd_sel_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (trig_sel == TTP_TSEL_RSVD) |=> !sync_trigger_out)
        else $error("reserved selection not quiet");

    // Counter run selection: immediate in sync mode, one cycle late when gated.
    run_sync_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (trig_sel == TTP_TSEL_ENABLE && core_in.master_slave_sync)
        |=> sync_trigger_out == $past(run_now))
        else $error("run signal mismatch");

    run_late_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (trig_sel == TTP_TSEL_ENABLE && core_in.gated_trigger && !core_in.master_slave_sync)
        |=> sync_trigger_out == $past(run_now, 2))
        else $error("gated run not delayed");

    run_fall_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (trig_sel == TTP_TSEL_ENABLE && gate_late && !core_in.master_slave_sync)
        |=> sync_trigger_out == $past(run_now, 2))
        else $error("gated run end not delayed");

    // Reset selection: slave-mode resets leave one cycle after the others.
    reset_late_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (trig_sel == TTP_TSEL_RESET && slave_reset_event) ##1 (trig_sel == TTP_TSEL_RESET)
        |=> sync_trigger_out)
        else $error("slave reset not delayed");

    reset_lag_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (trig_sel == TTP_TSEL_RESET && slave_reset_event && !reset_late) |=> !sync_trigger_out)
        else $error("slave reset left too early");

    reset_now_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (trig_sel == TTP_TSEL_RESET && core_in.reset_event && !core_in.slave_reset)
        |=> sync_trigger_out)
        else $error("reset pulse missing");

    // DMA request timing.
    dma_time_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (dma_sel && core_in.update_event) |=> dma_req_out)
        else $error("dma on update missing");

    dma_chan_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (!dma_sel && core_in.chan_event) |=> dma_req_out)
        else $error("dma on channel event missing");

    dma_quiet_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (dma_sel && !core_in.update_event) |=> !dma_req_out)
        else $error("dma request without update");

    // Channel bit preload.
    preload_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (preload && !core_in.commutate && !(upd_src && trig_in_rise))
        |=> $stable(chan_bits_active_out))
        else $error("preloaded bits changed early");

    direct_load_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (!preload) |=> chan_bits_active_out == $past(chan_bits_in))
        else $error("channel bits not immediate");

    com_load_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (preload && core_in.commutate) |=> chan_bits_active_out == $past(chan_bits_in))
        else $error("commutation transfer missing");

    trig_edge_load_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (preload && upd_src && trig_in_rise) |=> chan_bits_active_out == $past(chan_bits_in))
        else $error("trigger edge transfer missing");

    // Read data stand for one cycle only.
    read_stand_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (!bus_in.rd) |=> rdata_out == 16'h0000)
        else $error("read data outside answer cycle");
endmodule : ttp_trigger_preload
`default_nettype wire

// *** hw/ttp_defs.svh ***
// Purpose: Offsets, field positions and reset values of the trigger-out and preload block.
// Assumes: Register port with word offsets as below.
// Notes: Definitions only.
`ifndef TTP_DEFS_SVH
`define TTP_DEFS_SVH
`define TTP_CTL2_OFFSET 4'h4
`define TTP_SHADOW_OFFSET 4'h8
`define TTP_CTL2_RESET 16'h0000
`define TTP_CTL2_MASK 16'h7ffd
`define TTP_BIT_PRELOAD 0
`define TTP_BIT_UPD_SRC 2
`define TTP_BIT_DMA_SEL 3
`define TTP_TSEL_LSB 4
`define TTP_TSEL_MSB 6
`define TTP_CHAN_BITS 8
`define TTP_TRIG_LAG 1
`endif

// *** hw/ttp_pkg.sv ***
// Purpose: Types of the trigger-out and preload block.
// Assumes: Included header supplies numeric constants.
// Notes: None.
package ttp_pkg;
    typedef enum logic [2:0] {
        TTP_TSEL_RESET = 3'h0,
        TTP_TSEL_ENABLE = 3'h1,
        TTP_TSEL_UPDATE = 3'h2,
        TTP_TSEL_CMP_PULSE = 3'h3,
        TTP_TSEL_OC1 = 3'h4,
        TTP_TSEL_OC2 = 3'h5,
        TTP_TSEL_OC3 = 3'h6,
        TTP_TSEL_RSVD = 3'h7
    } ttp_tsel_e;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ttp_bus_s;
    typedef struct packed {
        logic counter_run_bit;
        logic gated_trigger;
        logic master_slave_sync;
        logic update_event;
        logic reset_event;
        logic slave_reset;
        logic chan1_capture;
        logic [2:0] out_ref;
        logic commutate;
        logic trigger_input;
        logic chan_event;
    } ttp_core_s;
endpackage : ttp_pkg

// *** hw/ttp_sync_delay.sv ***
// Purpose: Fixed delay line for single-bit timer signals.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Output comes from a register.
`timescale 1ns/1ps
`default_nettype none
module ttp_sync_delay #(
    parameter int DEPTH = 1
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Data.
    input wire logic d_in,
    output logic q_out
);
    logic [DEPTH-1:0] pipe_q;
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_stage
            always_ff @(posedge clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                    pipe_q[g] <= 1'b0;
                else
                    pipe_q[g] <= (g == 0) ? d_in : pipe_q[(g == 0) ? 0 : g-1];
            end
        end
    endgenerate
    assign q_out = pipe_q[DEPTH-1];
endmodule : ttp_sync_delay
`default_nettype wire

// *** testbench/ttp_slave_model.sv ***
// Purpose: Slave timer that counts master trigger pulses.
// Assumes: Trigger is sampled on the shared clock.
// Notes: Count is the slave's prescaled clock.
`timescale 1ns/1ps
`default_nettype none
module ttp_slave_model (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Trigger and count.
    input wire logic trig_in,
    output logic [7:0] count_out
);
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            count_out <= 8'h00;
        else
            count_out <= count_out + {7'h00, trig_in};
    end
endmodule : ttp_slave_model
`default_nettype wire

// *** testbench/tb.sv ***
// Purpose: Self-checking bench of the trigger-out and preload block.
// Assumes: Control at 4'h4, active channel bits at 4'h8.
// Notes: Each scenario drives and judges on its own.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb;
    import ttp_pkg::*;
    logic clk, rst_n, sync, dma;
    logic [15:0] rdata;
    logic [7:0] cb, act, cnt;
    ttp_bus_s b;
    ttp_core_s c;
    int n_fail = 0;
    int num_checks = 0;
    ttp_trigger_preload DUT (.sys_clk_in(clk), .rst_n_in(rst_n), .bus_in(b),
        .rdata_out(rdata), .core_in(c), .chan_bits_in(cb), .sync_trigger_out(sync),
        .dma_req_out(dma), .chan_bits_active_out(act));
    ttp_slave_model slave (.clk_in(clk), .rst_n_in(rst_n), .trig_in(sync), .count_out(cnt));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task finish_test;
        $display("checks %0d errors %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk) b <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk) b.wr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk) b <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk) b.rd <= 1'b0;
        #1 `CHK(rdata, e)
        @(posedge clk) #1 `CHK(rdata, 16'h0000)
    endtask : rd
    // Selected source, then one pulse; late sources lag one more cycle.
    task ev(input logic [2:0] m, input ttp_core_s v, input logic late);
        logic [7:0] n0;
        wr(4'h4, {9'h000, m, 4'h0});
        #1 n0 = cnt;
        @(posedge clk) c <= v;
        @(posedge clk) c <= '0;
        #1;
        if (late)
        begin
            `CHK(sync, 1'b0)
            @(posedge clk) #1;
        end
        `CHK(sync, 1'b1)
        @(posedge clk) #1 `CHK(sync, 1'b0)
        `CHK(cnt, n0 + 8'h01)
    endtask : ev
    task dm(input logic [15:0] ctl, input ttp_core_s v, input logic e);
        wr(4'h4, ctl);
        @(posedge clk) c <= v;
        @(posedge clk) c <= '0;
        #1 `CHK(dma, e)
    endtask : dm
    // Reserved selection: the trigger output stays low whatever the core does.
    task quiet(input logic [2:0] m, input ttp_core_s v);
        wr(4'h4, {9'h000, m, 4'h0});
        @(posedge clk) c <= v;
        @(posedge clk) c <= '0;
        #1 `CHK(sync, 1'b0)
        @(posedge clk) #1 `CHK(sync, 1'b0)
    endtask : quiet
    task pl(input logic [15:0] ctl, input logic [7:0] bits, input ttp_core_s v,
        input logic [7:0] e);
        wr(4'h4, ctl);
        @(posedge clk)
        begin
            cb <= bits;
            c <= v;
        end
        @(posedge clk) c <= '0;
        @(posedge clk) #1 `CHK(act, e)
    endtask : pl
    initial
    begin
        repeat (5000) @(posedge clk);
        n_fail++;
        finish_test;
    end
    initial
    begin
        rst_n = 1'b0;
        b = '0;
        c = '0;
        cb = 8'h00;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(4'h4, 16'h0000);
        wr(4'h4, 16'hffff);
        rd(4'h4, 16'h7ffd);
        rd(4'hc, 16'h0000);
        ev(3'h2, 13'h0200, 1'b0);
        ev(3'h3, 13'h0040, 1'b0);
        ev(3'h0, 13'h0100, 1'b0);
        ev(3'h0, 13'h0180, 1'b1);
        ev(3'h1, 13'h1000, 1'b0);
        ev(3'h1, 13'h0800, 1'b1);
        ev(3'h1, 13'h0c00, 1'b0);
        for (int i = 0; i < 3; i++)
            ev(3'(4 + i), 13'(13'h0008 << i), 1'b0);
        quiet(3'h7, 13'h1fff);
        dm(16'h0008, 13'h0200, 1'b1);
        dm(16'h0008, 13'h0001, 1'b0);
        dm(16'h0000, 13'h0200, 1'b0);
        dm(16'h0000, 13'h0001, 1'b1);
        pl(16'h0000, 8'ha5, 13'h0000, 8'ha5);
        pl(16'h0001, 8'h3c, 13'h0000, 8'ha5);
        pl(16'h0001, 8'h3c, 13'h0004, 8'h3c);
        pl(16'h0001, 8'h0f, 13'h0002, 8'h3c);
        pl(16'h0005, 8'h0f, 13'h0002, 8'h0f);
        rd(4'h8, 16'h000f);
        finish_test;
    end
endmodule : tb
`default_nettype wire
